// ==== logic/rsi_pkg.sv ====
// Shared constants and types for the reset-state initializer
package rsi_pkg;

  // Reset causes told apart by the block
  typedef enum logic [1:0] {
    RSI_CAUSE_POR,
    RSI_CAUSE_LVR,
    RSI_CAUSE_WDT_RUN,
    RSI_CAUSE_WDT_HALT
  } rsi_cause_t;

  // Register selectors on the core access port
  typedef enum logic [3:0] {
    RSI_REG_PTR0,
    RSI_REG_INT_CTL0,
    RSI_REG_INT_CTL1,
    RSI_REG_TMR_CTL0,
    RSI_REG_TMR_CTL1,
    RSI_REG_PA_DIR,
    RSI_REG_PB_DIR,
    RSI_REG_WDT_CTL,
    RSI_REG_STATUS
  } rsi_reg_t;

  // Number of byte registers kept by the block (status is built apart)
  localparam int RSI_NREG = 8;

  // Per-register default value, implemented bits, bits without reset
  localparam logic [RSI_NREG-1:0][7:0] RSI_DFLT = {
    8'h53, 8'h01, 8'hFF, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};
  localparam logic [RSI_NREG-1:0][7:0] RSI_IMPL = {
    8'hFF, 8'h01, 8'hFF, 8'hDF, 8'hDF, 8'hFF, 8'h7F, 8'hFF};
  localparam logic [RSI_NREG-1:0][7:0] RSI_UNK  = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

  // Field positions
  localparam int RSI_TO_BIT      = 5;
  localparam int RSI_PDF_BIT     = 4;
  localparam int RSI_TMR_ON_BIT  = 4;
  localparam int RSI_INT_GLB_BIT = 0;

  // Program counter and stack pointer
  localparam int             RSI_PC_W   = 11;
  localparam logic [10:0]    RSI_PC_RST = 11'h000;
  localparam int             RSI_SP_W   = 3;
  localparam logic [2:0]     RSI_SP_TOP = 3'h0;
  localparam logic [2:0]     RSI_SP_CLR = 3'h0;

  // Input synchroniser depth
  localparam int RSI_SYNC_N = 3;

endpackage

// ==== logic/rsi_cause.sv ====
// Reset cause recorder with one-cycle apply strobe
module rsi_cause
  import rsi_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  // Reset events and run state
  input  wire logic i_lvr_evt,
  input  wire logic i_wdt_evt,
  input  wire logic i_halted,
  // Recorded cause
  output rsi_cause_t o_cause,
  output logic       o_apply
);

  rsi_cause_t cause_r;
  logic       apply_r;

  // Cause latch; low voltage wins when both strike together
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cause_r <= RSI_CAUSE_POR;
    end else if (i_lvr_evt) begin
      cause_r <= RSI_CAUSE_LVR;
    end else if (i_wdt_evt) begin
      cause_r <= i_halted ? RSI_CAUSE_WDT_HALT
                          : RSI_CAUSE_WDT_RUN;
    end
  end

  // One apply strobe per synchronous reset event
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      apply_r <= 1'b0;
    end else begin
      apply_r <= i_lvr_evt | i_wdt_evt;
    end
  end

  assign o_cause = cause_r;
  assign o_apply = apply_r;

endmodule

// ==== logic/rsi_rreg.sv ====
// Byte register with per-bit default, no-reset and unimplemented bits
module rsi_rreg #(
  parameter logic [7:0] DFLT = 8'h00,
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] UNK  = 8'h00
) (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  // Default load and core write
  input  wire logic       i_load_dflt,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  // Stored value
  output logic      [7:0] o_q
);

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      if (IMPL[b] && !UNK[b]) begin : g_known
        // Known default on power-on and on loading resets
        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
          if (!i_arst_n) begin
            o_q[b] <= DFLT[b];
          end else if (i_load_dflt) begin
            o_q[b] <= DFLT[b];
          end else if (i_wr_en) begin
            o_q[b] <= i_wr_data[b];
          end
        end
      end else if (IMPL[b]) begin : g_unknown
        // No reset: content is undefined after reset, saves area
        always_ff @(posedge i_core_clk) begin
          if (i_wr_en) begin
            o_q[b] <= i_wr_data[b];
          end
        end
      end else begin : g_unimpl
        // No storage, reads zero whatever reset came
        assign o_q[b] = 1'b0;
      end
    end
  endgenerate

endmodule

// ==== logic/rsi_reset_state.sv ====
// Reset-state initializer: cause tracking, flags and reset defaults
//
// Operation
// - Power-on reset clears both the watchdog-timeout and power-down flags.
// - Low-voltage reset while running leaves both flags unchanged.
// - Watchdog reset while running sets the timeout flag, keeps power-down.
// - Watchdog reset while halted sets both flags.
// - Power-on reset disables every interrupt until software enables it.
// - Power-on reset clears the watchdog counter, which then counts at once.
// - Power-on reset switches the timers off until software turns them on.
// - Power-on reset makes every port pin an input.
// - Power-on reset points the stack pointer at the top of the stack.
// - Power-on, running watchdog and low-voltage resets load defaults; halted watchdog keeps them and clears the program counter.
// - Bits with unknown reset state have no reset logic.
// - Unimplemented bits have no storage and ignore every reset.
// - Halted watchdog reset clears program counter and stack pointer.
module rsi_reset_state
  import rsi_pkg::*;
#(
  parameter int WDT_TIMEOUT_CYC = 16384
) (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_arst_n,
  // Reset sources
  input  wire logic                i_low_voltage_reset,
  input  wire logic                i_halted,
  // Core flag controls
  input  wire logic                i_halt_enter,
  input  wire logic                i_clr_wdt,
  // Core register access
  input  wire logic                i_wr_en,
  input  wire rsi_reg_t            i_wr_sel,
  input  wire logic [7:0]          i_wr_data,
  input  wire rsi_reg_t            i_rd_sel,
  output logic      [7:0]          o_rd_data,
  // Program counter and stack
  input  wire logic                i_pc_load,
  input  wire logic [RSI_PC_W-1:0] i_pc_val,
  input  wire logic                i_pc_step,
  input  wire logic                i_push,
  input  wire logic                i_pop,
  output logic      [RSI_PC_W-1:0] o_pc,
  output logic      [RSI_SP_W-1:0] o_sp,
  // Status flags
  output logic                     o_watchdog_timeout_flag,
  output logic                     o_power_down_flag,
  // Controlled states
  output logic                     o_int_global_en,
  output logic      [7:0]          o_int_ctl0,
  output logic      [7:0]          o_int_ctl1,
  output logic      [1:0]          o_tmr_on,
  output logic      [7:0]          o_pa_dir,
  output logic                     o_pb_dir,
  // Reset report
  output rsi_cause_t               o_rst_cause,
  output logic                     o_rst_pulse
);

  localparam int WDT_W = $clog2(WDT_TIMEOUT_CYC);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TIMEOUT_CYC - 1);

  logic [RSI_SYNC_N-1:0]  lvr_sync_r;
  logic                   lvr_lvl_r;
  logic                   lvr_evt;
  logic [WDT_W-1:0]       wdt_cnt_r;
  logic                   wdt_evt;
  rsi_cause_t             cause;
  logic                   apply;
  logic                   load_dflt;
  logic                   to_r;
  logic                   pdf_r;
  logic [RSI_PC_W-1:0]    pc_r;
  logic [RSI_SP_W-1:0]    sp_r;
  logic [7:0]             rd_data_r;
  logic [RSI_NREG-1:0][7:0] reg_q;
  logic [7:0]             status;

  // Low-voltage detector is analog and asynchronous: three-stage sync
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvr_sync_r <= '0;
    end else begin
      lvr_sync_r <= {lvr_sync_r[RSI_SYNC_N-2:0], i_low_voltage_reset};
    end
  end

  // Level accepted only when last two stages agree, filters glitches
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvr_lvl_r <= 1'b0;
    end else if (lvr_sync_r[2] == lvr_sync_r[1]) begin
      lvr_lvl_r <= lvr_sync_r[2];
    end
  end

  assign lvr_evt = (lvr_sync_r[2] == lvr_sync_r[1]) &&
                   lvr_sync_r[2] && !lvr_lvl_r;

  // Watchdog counts from reset on with no software step needed
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdt_cnt_r <= '0;
    end else if (apply || i_clr_wdt || wdt_evt) begin
      wdt_cnt_r <= '0;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  assign wdt_evt = (wdt_cnt_r == WDT_LAST);

  // Cause tracking
  rsi_cause u_cause (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_lvr_evt  (lvr_evt),
    .i_wdt_evt  (wdt_evt),
    .i_halted   (i_halted),
    .o_cause    (cause),
    .o_apply    (apply)
  );

  // Halted watchdog keeps register contents, all other causes reload
  assign load_dflt = apply && (cause != RSI_CAUSE_WDT_HALT);

  // Byte registers: interrupt, timer, port direction, watchdog, pointer
  genvar r;
  generate
    for (r = 0; r < RSI_NREG; r++) begin : g_reg
      rsi_rreg #(
        .DFLT (RSI_DFLT[r]),
        .IMPL (RSI_IMPL[r]),
        .UNK  (RSI_UNK[r])
      ) u_reg (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_load_dflt (load_dflt),
        .i_wr_en     (i_wr_en && (i_wr_sel == rsi_reg_t'(r))),
        .i_wr_data   (i_wr_data),
        .o_q         (reg_q[r])
      );
    end
  endgenerate

  // Reset flags; an apply in the same cycle as a clear wins
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      to_r  <= 1'b0;
      pdf_r <= 1'b0;
    end else if (apply) begin
      unique case (cause)
        RSI_CAUSE_WDT_RUN: begin
          to_r <= 1'b1;
        end
        RSI_CAUSE_WDT_HALT: begin
          to_r  <= 1'b1;
          pdf_r <= 1'b1;
        end
        RSI_CAUSE_LVR: begin
          to_r  <= to_r;
          pdf_r <= pdf_r;
        end
        RSI_CAUSE_POR: begin
          to_r  <= to_r;
          pdf_r <= pdf_r;
        end
      endcase
    end else begin
      to_r  <= to_r & ~i_clr_wdt;
      pdf_r <= i_halt_enter | (pdf_r & ~i_clr_wdt);
    end
  end

  // Program counter cleared by every reset cause
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_r <= RSI_PC_RST;
    end else if (apply) begin
      pc_r <= RSI_PC_RST;
    end else if (i_pc_load) begin
      pc_r <= i_pc_val;
    end else if (i_pc_step) begin
      pc_r <= pc_r + 1'b1;
    end
  end

  // Stack pointer; push wins if both strobes come together
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_r <= RSI_SP_TOP;
    end else if (apply) begin
      sp_r <= (cause == RSI_CAUSE_WDT_HALT) ? RSI_SP_CLR
                                            : RSI_SP_TOP;
    end else if (i_push) begin
      sp_r <= sp_r + 1'b1;
    end else if (i_pop) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // Status byte: only the two reset flags are kept here
  always_comb begin
    status = 8'h00;
    status[RSI_TO_BIT]  = to_r;
    status[RSI_PDF_BIT] = pdf_r;
  end

  // Registered read port, one cycle latency
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_data_r <= 8'h00;
    end else if (i_rd_sel == RSI_REG_STATUS) begin
      rd_data_r <= status;
    end else if (int'(i_rd_sel) < RSI_NREG) begin
      rd_data_r <= reg_q[i_rd_sel[2:0]];
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  // Outputs straight from flops
  assign o_rd_data               = rd_data_r;
  assign o_pc                    = pc_r;
  assign o_sp                    = sp_r;
  assign o_watchdog_timeout_flag = to_r;
  assign o_power_down_flag       = pdf_r;
  assign o_int_ctl0              = reg_q[RSI_REG_INT_CTL0];
  assign o_int_ctl1              = reg_q[RSI_REG_INT_CTL1];
  assign o_int_global_en         =
    reg_q[RSI_REG_INT_CTL0][RSI_INT_GLB_BIT];
  assign o_tmr_on = {reg_q[RSI_REG_TMR_CTL1][RSI_TMR_ON_BIT],
                     reg_q[RSI_REG_TMR_CTL0][RSI_TMR_ON_BIT]};
  assign o_pa_dir                = reg_q[RSI_REG_PA_DIR];
  assign o_pb_dir                = reg_q[RSI_REG_PB_DIR][0];
  assign o_rst_cause             = cause;
  assign o_rst_pulse             = apply;

endmodule

// ==== sim/rsi_reset_state_assertions.sv ====
// Checker for reset-cause flags and reset defaults of rsi_reset_state
module rsi_reset_state_assertions
  import rsi_pkg::*;
#(
  parameter int WDT_TIMEOUT_CYC = 16384
) (
  input wire logic                i_core_clk,
  input wire logic                i_arst_n,
  input wire logic                i_clr_wdt,
  input wire logic [RSI_PC_W-1:0] o_pc,
  input wire logic [RSI_SP_W-1:0] o_sp,
  input wire logic                o_watchdog_timeout_flag,
  input wire logic                o_power_down_flag,
  input wire logic      [7:0]     o_int_ctl0,
  input wire logic      [7:0]     o_int_ctl1,
  input wire logic      [1:0]     o_tmr_on,
  input wire logic      [7:0]     o_pa_dir,
  input wire rsi_cause_t          o_rst_cause,
  input wire logic                o_rst_pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] wdt_age_r;
  // Cycles since last watchdog restart; bounds the free-running expiry
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) wdt_age_r <= 16'h0000;
    else if (i_clr_wdt || o_rst_pulse) wdt_age_r <= 16'h0000;
    else wdt_age_r <= wdt_age_r + 16'h0001;
  end
  AST_POR_FLAGS: assert property ($rose(i_arst_n) |->
    !o_watchdog_timeout_flag && !o_power_down_flag) else $error("por flags");
  AST_POR_INT: assert property ($rose(i_arst_n) |->
    o_int_ctl0 == 8'h00 && o_int_ctl1 == 8'h00) else $error("por ints");
  AST_POR_TMR: assert property ($rose(i_arst_n) |->
    o_tmr_on == 2'h0) else $error("por timers");
  AST_POR_PORT: assert property ($rose(i_arst_n) |->
    o_pa_dir == 8'hFF) else $error("por port dir");
  AST_POR_SP: assert property ($rose(i_arst_n) |->
    o_sp == RSI_SP_TOP && o_rst_cause == RSI_CAUSE_POR) else $error("por sp");
  AST_WDT_RUNS: assert property (
    wdt_age_r <= 16'(WDT_TIMEOUT_CYC + 2)) else $error("watchdog stalled");
  AST_LVR_KEEP: assert property (o_rst_pulse &&
    o_rst_cause == RSI_CAUSE_LVR |=> $stable(o_watchdog_timeout_flag) &&
    $stable(o_power_down_flag)) else $error("lvr flags");
  AST_WDT_RUN: assert property (o_rst_pulse &&
    o_rst_cause == RSI_CAUSE_WDT_RUN |=> o_watchdog_timeout_flag &&
    $stable(o_power_down_flag)) else $error("wdt run flags");
  AST_WDT_HALT: assert property (o_rst_pulse &&
    o_rst_cause == RSI_CAUSE_WDT_HALT |=> o_watchdog_timeout_flag &&
    o_power_down_flag && o_pc == RSI_PC_RST && o_sp == RSI_SP_CLR)
    else $error("wdt halt state");
  AST_DFLT_LOAD: assert property (o_rst_pulse &&
    o_rst_cause != RSI_CAUSE_WDT_HALT |=> o_pa_dir == 8'hFF &&
    o_int_ctl0 == 8'h00 && o_pc == RSI_PC_RST) else $error("default load");
  AST_HALT_KEEP: assert property (o_rst_pulse &&
    o_rst_cause == RSI_CAUSE_WDT_HALT |=> $stable(o_pa_dir) &&
    $stable(o_int_ctl1)) else $error("halt keeps regs");
endmodule

bind rsi_reset_state rsi_reset_state_assertions #(
  .WDT_TIMEOUT_CYC(WDT_TIMEOUT_CYC)
) u_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_clr_wdt(i_clr_wdt),
  .o_pc(o_pc), .o_sp(o_sp), .o_int_ctl0(o_int_ctl0),
  .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
  .o_power_down_flag(o_power_down_flag), .o_int_ctl1(o_int_ctl1),
  .o_tmr_on(o_tmr_on), .o_pa_dir(o_pa_dir), .o_rst_cause(o_rst_cause),
  .o_rst_pulse(o_rst_pulse)
);

// ==== sim/rsi_reset_state_tb.sv ====
// Directed testbench for the reset-state initializer
module rsi_reset_state_tb
  import rsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, low_voltage_reset = 1'b0, hlt = 1'b0, hen = 1'b0;
  logic clr = 1'b0, wen = 1'b0, pld = 1'b0, pst = 1'b0, psh = 1'b0;
  logic pop = 1'b0;
  rsi_reg_t wsel = RSI_REG_PTR0, rsel = RSI_REG_STATUS;
  logic [7:0]  wdat = 8'h00, rd, ic0, ic1, pa;
  logic [10:0] pcv = 11'h000, pc;
  logic [2:0]  sp;
  logic [1:0]  tmr;
  logic        tof, power_down_flag, gie, pb, pls;
  rsi_cause_t  cause, seen;
  int num_errors = 0, check_count = 0;
  // Short watchdog span keeps each expiry within a few dozen cycles
  rsi_reset_state #(.WDT_TIMEOUT_CYC(16)) DUT (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_low_voltage_reset(low_voltage_reset),
    .i_halted(hlt), .i_halt_enter(hen), .i_clr_wdt(clr), .i_wr_en(wen),
    .i_wr_sel(wsel), .i_wr_data(wdat), .i_rd_sel(rsel), .o_rd_data(rd),
    .i_pc_load(pld), .i_pc_val(pcv), .i_pc_step(pst), .i_push(psh),
    .i_pop(pop), .o_pc(pc), .o_sp(sp), .o_watchdog_timeout_flag(tof),
    .o_power_down_flag(power_down_flag), .o_int_global_en(gie), .o_int_ctl0(ic0),
    .o_int_ctl1(ic1), .o_tmr_on(tmr), .o_pa_dir(pa), .o_pb_dir(pb),
    .o_rst_cause(cause), .o_rst_pulse(pls));
  always #4 clk = ~clk;
  // Step to just after the next edge so drives and samples never race
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(rsi_reg_t s, logic [7:0] d);
    wsel = s; wdat = d; wen = 1'b1;
    cyc();
    wen = 1'b0;
  endtask
  // Bounded wait; cause sampled in the pulse cycle, then step past it
  task automatic wait_pulse();
    int n;
    n = 0;
    while (pls !== 1'b1 && n < 60) begin
      cyc();
      n++;
    end
    chk("pulse seen", 11'h001, {10'h000, pls});
    seen = cause;
    cyc();
  endtask
  task automatic t_por();
    chk("tof", 11'h000, tof);
    chk("pdf", 11'h000, power_down_flag);
    chk("int", 11'h000, {gie, ic0});
    chk("tmr", 11'h000, tmr);
    chk("dirs", 11'h1FF, {pb, pa});
    chk("sp", RSI_SP_TOP, sp);
    chk("cause", RSI_CAUSE_POR, cause);
    rsel = RSI_REG_STATUS;
    cyc();
    chk("status", 11'h000, rd);
    $display("test por done");
  endtask
  task automatic t_wdt_run();
    clr = 1'b1; cyc(); clr = 1'b0;
    hen = 1'b1; cyc(); hen = 1'b0;
    wr(RSI_REG_INT_CTL0, 8'hFF);
    wr(RSI_REG_TMR_CTL0, 8'h10);
    chk("ctl0 impl", 11'h07F, ic0);
    chk("tmr on", 11'h001, tmr);
    wait_pulse();
    chk("cause", RSI_CAUSE_WDT_RUN, seen);
    chk("flags", 11'h003, {tof, power_down_flag});
    chk("dflt", 11'h000, {tmr, ic0});
    $display("test wdt run done");
  endtask
  task automatic t_lvr();
    wr(RSI_REG_PA_DIR, 8'h0F);
    low_voltage_reset = 1'b1;
    wait_pulse();
    low_voltage_reset = 1'b0;
    chk("cause", RSI_CAUSE_LVR, seen);
    chk("flags", 11'h003, {tof, power_down_flag});
    chk("pa dflt", 11'h0FF, pa);
    $display("test lvr done");
  endtask
  task automatic t_wdt_halt();
    clr = 1'b1; psh = 1'b1; cyc(); clr = 1'b0;
    pld = 1'b1; pcv = 11'h123; cyc(); psh = 1'b0; pld = 1'b0;
    // Step and pop exercise the core-side pointer paths before reset
    pst = 1'b1; pop = 1'b1; cyc(); pst = 1'b0; pop = 1'b0;
    chk("pc step", 11'h124, pc);
    chk("sp pop", 11'h001, sp);
    wr(RSI_REG_PA_DIR, 8'h0F);
    wr(RSI_REG_INT_CTL1, 8'hAA);
    hlt = 1'b1;
    wait_pulse();
    hlt = 1'b0;
    chk("cause", RSI_CAUSE_WDT_HALT, seen);
    chk("flags", 11'h003, {tof, power_down_flag});
    chk("pc", RSI_PC_RST, pc);
    chk("sp", RSI_SP_CLR, sp);
    chk("kept", 11'h0AF, {ic1[7:4], pa[3:0]});
    cyc();
    chk("status", 11'h030, rd);
    $display("test wdt halt done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run is under a hundred cycles; the 2500-cycle limit cuts a hang short
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_por();
    t_wdt_run();
    t_lvr();
    t_wdt_halt();
    final_report();
  end
endmodule
